// ===== common/bcrc_defines.svh
// register offsets, field positions, reset values and constants for the crc unit
`ifndef BCRC_DEFINES_SVH
`define BCRC_DEFINES_SVH

`define BCRC_ADDR_CONTROL 8'h84
`define BCRC_ADDR_INPUT 8'h85
`define BCRC_ADDR_RESULT 8'h86
`define BCRC_ADDR_REVERSE 8'hdf

`define BCRC_BIT_WIDTHSEL 4
`define BCRC_BIT_INIT 3
`define BCRC_BIT_INITVAL 2
`define BCRC_PTR_LSB 0
`define BCRC_PTR_MSB 1

`define BCRC_RESET_BYTE 8'h00
`define BCRC_POLY16 16'h1021
`define BCRC_POLY32 32'h04c11db7
`define BCRC_INIT_ZERO 32'h00000000
`define BCRC_INIT_ONES 32'hffffffff

`endif

// ===== common/bcrc_pkg.sv
// types shared by the crc unit
package bcrc_pkg;
  typedef logic [7:0] bcrc_byte_t;
  typedef logic [7:0] bcrc_addr_t;
  typedef logic [31:0] bcrc_result_t;
endpackage

// ===== logic/bcrc_unit.sv
// byte-fed crc unit with bit reverse register on the special function bus
//
// What this block does
// - 16-bit or 32-bit result by width select
// - poly 0x1021 or 0x04c11db7 by width select
// - control bit 3 write loads result; write-only
// - init value zeros or ones by select
// - each input byte folded into result
// - result holds until init, overwrite, byte
// - data port accesses pointer-selected result byte
// - 16-bit mode: pointer bit 0 picks byte
// - 32-bit mode: pointer picks one of four bytes
// - bit reverse register reads back mirrored
// - control bits 7-5 read zero
`timescale 1ns/1ns
`include "bcrc_defines.svh"

module bcrc_unit (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // special function register access, same clock domain as the core
  input wire bcrc_pkg::bcrc_addr_t sfrAddr,
  input wire logic sfrWe,
  input wire logic sfrRe,
  input wire bcrc_pkg::bcrc_byte_t sfrWdata,
  output bcrc_pkg::bcrc_byte_t sfrRdata,
  output logic sfrRvalid
);
  import bcrc_pkg::*;

  logic widthSel_r;
  logic initVal_r;
  logic [1:0] pointer_r;
  bcrc_result_t result_r;
  bcrc_result_t result_nxt;
  bcrc_byte_t reverse_r;
  bcrc_byte_t lastIn_r;
  bcrc_byte_t rdata_nxt;

  // one byte through the crc, msb first, no reflection
  function automatic bcrc_result_t crcByte(input bcrc_result_t cur,
                                            input bcrc_byte_t din,
                                            input logic wide);
    bcrc_result_t c;
    logic fb;
    c = cur;
    for (int i = 7; i >= 0; i--) begin
      if (wide) begin
        fb = c[31] ^ din[i];
        c = {c[30:0], 1'b0} ^ (fb ? `BCRC_POLY32 : 32'h00000000);
      end else begin
        // upper half kept so a later width switch sees the old bits
        fb = c[15] ^ din[i];
        c = {c[31:16], c[14:0], 1'b0} ^
            {16'h0000, (fb ? `BCRC_POLY16 : 16'h0000)};
      end
    end
    return c;
  endfunction

  // byte lane selected by the pointer; 16-bit mode ignores pointer bit 1
  function automatic logic [1:0] laneOf(input logic [1:0] ptr,
                                         input logic wide);
    return wide ? ptr : {1'b0, ptr[0]};
  endfunction

  function automatic bcrc_byte_t mirror(input bcrc_byte_t b);
    bcrc_byte_t m;
    for (int i = 0; i < 8; i++) begin
      m[i] = b[7 - i];
    end
    return m;
  endfunction

  wire logic wrCtl = sfrWe && (sfrAddr == `BCRC_ADDR_CONTROL);
  wire logic wrIn = sfrWe && (sfrAddr == `BCRC_ADDR_INPUT);
  wire logic wrRes = sfrWe && (sfrAddr == `BCRC_ADDR_RESULT);
  wire logic wrRev = sfrWe && (sfrAddr == `BCRC_ADDR_REVERSE);
  wire logic [1:0] lane = laneOf(pointer_r, widthSel_r);

  // control fields; the init bit is a strobe and is not stored
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      widthSel_r <= 1'b0;
      initVal_r <= 1'b0;
      pointer_r <= 2'h0;
    end else if (wrCtl) begin
      widthSel_r <= sfrWdata[`BCRC_BIT_WIDTHSEL];
      initVal_r <= sfrWdata[`BCRC_BIT_INITVAL];
      pointer_r <= sfrWdata[`BCRC_PTR_MSB:`BCRC_PTR_LSB];
    end
  end

  // init uses the value select written in the same control write
  always_comb begin
    result_nxt = result_r;
    if (wrCtl && sfrWdata[`BCRC_BIT_INIT]) begin
      result_nxt = sfrWdata[`BCRC_BIT_INITVAL] ? `BCRC_INIT_ONES
                                               : `BCRC_INIT_ZERO;
    end else if (wrIn) begin
      result_nxt = crcByte(result_r, sfrWdata, widthSel_r);
    end else if (wrRes) begin
      case (lane)
        2'h0: result_nxt[7:0] = sfrWdata;
        2'h1: result_nxt[15:8] = sfrWdata;
        2'h2: result_nxt[23:16] = sfrWdata;
        2'h3: result_nxt[31:24] = sfrWdata;
        default: result_nxt = result_r;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      result_r <= `BCRC_INIT_ZERO;
    end else begin
      result_r <= result_nxt;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reverse_r <= `BCRC_RESET_BYTE;
      lastIn_r <= `BCRC_RESET_BYTE;
    end else begin
      if (wrRev) begin
        reverse_r <= mirror(sfrWdata);
      end
      if (wrIn) begin
        lastIn_r <= sfrWdata;
      end
    end
  end

  // registered read data, one cycle after the read strobe
  always_comb begin
    rdata_nxt = `BCRC_RESET_BYTE;
    case (sfrAddr)
      `BCRC_ADDR_CONTROL:
        rdata_nxt = {3'h0, widthSel_r, 1'b0, initVal_r, pointer_r};
      `BCRC_ADDR_INPUT:
        rdata_nxt = lastIn_r;
      `BCRC_ADDR_RESULT:
        rdata_nxt = result_r[8*lane +: 8];
      `BCRC_ADDR_REVERSE:
        rdata_nxt = reverse_r;
      default:
        rdata_nxt = `BCRC_RESET_BYTE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sfrRdata <= `BCRC_RESET_BYTE;
      sfrRvalid <= 1'b0;
    end else begin
      sfrRvalid <= sfrRe;
      sfrRdata <= sfrRe ? rdata_nxt : `BCRC_RESET_BYTE;
    end
  end

  // init strobe and control fields
  AST_INIT_ONES: assert property (@(posedge clk) disable iff (!nrst)
    wrCtl && sfrWdata[`BCRC_BIT_INIT] && sfrWdata[`BCRC_BIT_INITVAL]
    |=> result_r == `BCRC_INIT_ONES)
    else $error("init to ones failed");

  AST_INIT_ZERO: assert property (@(posedge clk) disable iff (!nrst)
    wrCtl && sfrWdata[`BCRC_BIT_INIT] && !sfrWdata[`BCRC_BIT_INITVAL]
    |=> result_r == `BCRC_INIT_ZERO)
    else $error("init to zeros failed");

  AST_CTL_WIDTH: assert property (@(posedge clk) disable iff (!nrst)
    wrCtl |=> widthSel_r == $past(sfrWdata[`BCRC_BIT_WIDTHSEL]))
    else $error("width select not stored");

  AST_CTL_VAL: assert property (@(posedge clk) disable iff (!nrst)
    wrCtl |=> initVal_r == $past(sfrWdata[`BCRC_BIT_INITVAL]))
    else $error("init value select not stored");

  AST_CTL_PTR: assert property (@(posedge clk) disable iff (!nrst)
    wrCtl |=> pointer_r == $past(sfrWdata[1:0]))
    else $error("pointer not stored");

  AST_PTR: assert property (@(posedge clk) disable iff (!nrst)
    !wrCtl |=> $stable(pointer_r))
    else $error("pointer changed without control write");

  AST_PTR_PORT: assert property (@(posedge clk) disable iff (!nrst)
    (wrRes || (sfrRe && sfrAddr == `BCRC_ADDR_RESULT)) && !wrCtl
    |=> $stable(pointer_r))
    else $error("data port access moved the pointer");

  // running result
  AST_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    !wrCtl && !wrIn && !wrRes |=> $stable(result_r))
    else $error("result changed without cause");

  AST_HOLD_CTL: assert property (@(posedge clk) disable iff (!nrst)
    wrCtl && !sfrWdata[`BCRC_BIT_INIT] |=> $stable(result_r))
    else $error("control write without init moved result");

  AST_FOLD: assert property (@(posedge clk) disable iff (!nrst)
    wrIn |=> result_r == crcByte($past(result_r), $past(sfrWdata),
                                 $past(widthSel_r)))
    else $error("input byte not folded");

  // a single one bit from zero leaves exactly the polynomial
  AST_POLY32: assert property (@(posedge clk) disable iff (!nrst)
    wrIn && widthSel_r && result_r == 32'h00000000 && sfrWdata == 8'h01
    |=> result_r == `BCRC_POLY32)
    else $error("32-bit polynomial wrong");

  AST_POLY16: assert property (@(posedge clk) disable iff (!nrst)
    wrIn && !widthSel_r && result_r == 32'h00000000 && sfrWdata == 8'h01
    |=> result_r == {16'h0000, `BCRC_POLY16})
    else $error("16-bit polynomial wrong");

  AST_UPPER16: assert property (@(posedge clk) disable iff (!nrst)
    wrIn && !widthSel_r |=> $stable(result_r[31:16]))
    else $error("16-bit fold touched upper half");

  AST_PORT_WR: assert property (@(posedge clk) disable iff (!nrst)
    wrRes && widthSel_r && pointer_r == 2'h2
    |=> result_r[23:16] == $past(sfrWdata) && $stable(result_r[15:0]))
    else $error("data port write missed its byte");

  // bit reverse register
  AST_MIRROR: assert property (@(posedge clk) disable iff (!nrst)
    wrRev |=> reverse_r == {<<{$past(sfrWdata)}})
    else $error("bit reverse wrong");

  AST_REV_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    !wrRev |=> $stable(reverse_r))
    else $error("bit reverse changed without write");

  // read path; data reflects state before a same-cycle write
  AST_CTL_RD: assert property (@(posedge clk) disable iff (!nrst)
    sfrRe && sfrAddr == `BCRC_ADDR_CONTROL |=> sfrRdata[7:5] == 3'h0
    && sfrRdata[`BCRC_BIT_INIT] == 1'b0)
    else $error("control reserved bits not zero");

  AST_CTL_FIELDS: assert property (@(posedge clk) disable iff (!nrst)
    sfrRe && sfrAddr == `BCRC_ADDR_CONTROL
    |=> sfrRdata[4:0] == {$past(widthSel_r), 1'b0, $past(initVal_r),
                          $past(pointer_r)})
    else $error("control fields read wrong");

  AST_LANE16: assert property (@(posedge clk) disable iff (!nrst)
    sfrRe && sfrAddr == `BCRC_ADDR_RESULT && !widthSel_r
    |=> sfrRdata == ($past(pointer_r[0]) ? $past(result_r[15:8])
                                         : $past(result_r[7:0])))
    else $error("16-bit lane select wrong");

  AST_LANE32: assert property (@(posedge clk) disable iff (!nrst)
    sfrRe && sfrAddr == `BCRC_ADDR_RESULT && widthSel_r
    && pointer_r == 2'h3 && !wrRes && !wrIn && !wrCtl
    |=> sfrRdata == result_r[31:24])
    else $error("32-bit lane select wrong");

  AST_LANE32_ANY: assert property (@(posedge clk) disable iff (!nrst)
    sfrRe && sfrAddr == `BCRC_ADDR_RESULT && widthSel_r
    |=> sfrRdata == 8'($past(result_r) >> {$past(pointer_r), 3'b000}))
    else $error("32-bit lane read wrong");

  AST_INPUT_RD: assert property (@(posedge clk) disable iff (!nrst)
    sfrRe && sfrAddr == `BCRC_ADDR_INPUT |=> sfrRdata == $past(lastIn_r))
    else $error("input register read wrong");

  AST_REV_RD: assert property (@(posedge clk) disable iff (!nrst)
    sfrRe && sfrAddr == `BCRC_ADDR_REVERSE
    |=> sfrRdata == $past(reverse_r))
    else $error("bit reverse read wrong");

  AST_UNMAPPED: assert property (@(posedge clk) disable iff (!nrst)
    sfrRe && sfrAddr != `BCRC_ADDR_CONTROL && sfrAddr != `BCRC_ADDR_INPUT
    && sfrAddr != `BCRC_ADDR_RESULT && sfrAddr != `BCRC_ADDR_REVERSE
    |=> sfrRdata == 8'h00)
    else $error("unmapped read not zero");

  // read handshake: valid and data follow the read strobe one cycle later, for as long as it is held
  AST_VALID: assert property (@(posedge clk) disable iff (!nrst)
    sfrRe |=> sfrRvalid)
    else $error("read valid missing");

  AST_VALID_LOW: assert property (@(posedge clk) disable iff (!nrst)
    !sfrRe |=> !sfrRvalid && sfrRdata == 8'h00)
    else $error("read valid or data without read");
endmodule

// ===== bench/bcrc_core_model.sv
// core-side model making special function register accesses
`timescale 1ns/1ns
module bcrc_core_model (
  // clock
  input wire logic clk,
  // register bus towards the unit
  output bcrc_pkg::bcrc_addr_t sfrAddr,
  output logic sfrWe,
  output logic sfrRe,
  output bcrc_pkg::bcrc_byte_t sfrWdata,
  input wire bcrc_pkg::bcrc_byte_t sfrRdata,
  input wire logic sfrRvalid
);
  import bcrc_pkg::*;
  initial begin
    sfrAddr = 8'h00;
    sfrWe = 1'b0;
    sfrRe = 1'b0;
    sfrWdata = 8'h00;
  end
  task automatic wr(input bcrc_addr_t a, input bcrc_byte_t d);
    @(negedge clk);
    sfrAddr = a;
    sfrWdata = d;
    sfrWe = 1'b1;
    @(negedge clk);
    sfrWe = 1'b0;
    // released lines must not keep looking valid
    sfrAddr = ~a;
    sfrWdata = ~d;
  endtask
  task automatic rd(input bcrc_addr_t a, output bcrc_byte_t d);
    @(negedge clk);
    sfrAddr = a;
    sfrRe = 1'b1;
    @(negedge clk);
    sfrRe = 1'b0;
    sfrAddr = ~a;
    d = (sfrRvalid === 1'b1) ? sfrRdata : 8'hxx;
  endtask
endmodule

// ===== bench/test_bcrc_unit.sv
// self-checking bench for the byte-fed crc unit
`timescale 1ns/1ns
`include "bcrc_defines.svh"
module test_bcrc_unit;
  import bcrc_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  bcrc_addr_t sfrAddr;
  logic sfrWe;
  logic sfrRe;
  bcrc_byte_t sfrWdata;
  bcrc_byte_t sfrRdata;
  logic sfrRvalid;
  bcrc_result_t exp32 = 32'h0376e6e7;
  bcrc_result_t poly32 = `BCRC_POLY32;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  bcrc_unit bcrc_unit_inst (.clk(clk), .nrst(nrst), .sfrAddr(sfrAddr),
    .sfrWe(sfrWe), .sfrRe(sfrRe), .sfrWdata(sfrWdata),
    .sfrRdata(sfrRdata), .sfrRvalid(sfrRvalid));
  bcrc_core_model bcrc_core_model_inst (.clk(clk), .sfrAddr(sfrAddr),
    .sfrWe(sfrWe), .sfrRe(sfrRe), .sfrWdata(sfrWdata),
    .sfrRdata(sfrRdata), .sfrRvalid(sfrRvalid));
  task automatic chk(input bcrc_byte_t got, input bcrc_byte_t exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input bcrc_addr_t a, input bcrc_byte_t exp);
    bcrc_byte_t d;
    bcrc_core_model_inst.rd(a, d);
    chk(d, exp);
  endtask
  task automatic wr(input bcrc_addr_t a, input bcrc_byte_t d);
    bcrc_core_model_inst.wr(a, d);
  endtask
  // ascii 1..9, the usual check string
  task automatic feed();
    for (int i = 1; i <= 9; i++) wr(`BCRC_ADDR_INPUT, 8'h30 + 8'(i));
  endtask
  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    rchk(`BCRC_ADDR_CONTROL, 8'h00);
    rchk(`BCRC_ADDR_RESULT, 8'h00);
    rchk(`BCRC_ADDR_REVERSE, 8'h00);
    rchk(8'h87, 8'h00);
    $display("test reset done");
    wr(`BCRC_ADDR_CONTROL, 8'hff);
    rchk(`BCRC_ADDR_CONTROL, 8'h17);
    rchk(`BCRC_ADDR_RESULT, 8'hff);
    wr(`BCRC_ADDR_CONTROL, 8'h0b);
    rchk(`BCRC_ADDR_RESULT, 8'h00);
    $display("test control done");
    wr(`BCRC_ADDR_CONTROL, 8'h1c);
    feed();
    for (int p = 0; p < 4; p++) begin
      wr(`BCRC_ADDR_CONTROL, 8'h10 | 8'(p));
      rchk(`BCRC_ADDR_RESULT, exp32[8*p+:8]);
      rchk(`BCRC_ADDR_RESULT, exp32[8*p+:8]);
    end
    $display("test crc32 done");
    wr(`BCRC_ADDR_CONTROL, 8'h08);
    feed();
    for (int p = 0; p < 4; p++) begin
      wr(`BCRC_ADDR_CONTROL, 8'(p));
      rchk(`BCRC_ADDR_RESULT, p[0] ? 8'h31 : 8'hc3);
    end
    rchk(`BCRC_ADDR_INPUT, 8'h39);
    $display("test crc16 done");
    wr(`BCRC_ADDR_CONTROL, 8'h12);
    wr(`BCRC_ADDR_RESULT, 8'ha5);
    rchk(`BCRC_ADDR_RESULT, 8'ha5);
    wr(`BCRC_ADDR_CONTROL, 8'h10);
    rchk(`BCRC_ADDR_RESULT, 8'hc3);
    wr(`BCRC_ADDR_REVERSE, 8'hc0);
    rchk(`BCRC_ADDR_REVERSE, 8'h03);
    wr(`BCRC_ADDR_REVERSE, 8'h05);
    rchk(`BCRC_ADDR_REVERSE, 8'ha0);
    $display("test port and reverse done");
    wr(`BCRC_ADDR_CONTROL, 8'h18);
    wr(`BCRC_ADDR_INPUT, 8'h01);
    for (int p = 0; p < 4; p++) begin
      wr(`BCRC_ADDR_CONTROL, 8'h10 | 8'(p));
      rchk(`BCRC_ADDR_RESULT, poly32[8*p+:8]);
    end
    wr(`BCRC_ADDR_CONTROL, 8'h08);
    wr(`BCRC_ADDR_INPUT, 8'h01);
    for (int p = 0; p < 2; p++) begin
      wr(`BCRC_ADDR_CONTROL, 8'(p));
      rchk(`BCRC_ADDR_RESULT, p[0] ? 8'h10 : 8'h21);
    end
    $display("test polynomial done");
    print_verdict();
  end
endmodule
